//--- rtl/wir_reg_port.sv
module wir_reg_port (
    // system clock and reset
    input wire logic clk,
    input wire logic rst,
    // two-wire bus; scl clocks the link logic
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // address strap pin
    input wire logic strap_pin,
    // active channel settings
    output logic [wir_pkg::NUM_CH-1:0][7:0] duty_level,
    output logic [wir_pkg::NUM_CH-1:0] channel_on,
    output logic [wir_pkg::NUM_CH-1:0][1:0] current_scale_field,
    // global settings
    output logic soft_power_down_bit,
    output logic global_output_off,
    output logic pwm_rate_select_bit
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and bus condition detect (clk domain)

    logic [2:0] pin_s;
    logic scl_s, sda_s, strap_s;
    logic scl_d_r, sda_d_r;
    logic [1:0] settle_r;
    logic start_det, stop_det;
    logic in_frame_r, engine_run_r;

    wir_sync2 #(.WIDTH(3)) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .d({scl, sda_i, strap_pin}),
        .q(pin_s)
    );

    assign scl_s = pin_s[2];
    assign sda_s = pin_s[1];
    assign strap_s = pin_s[0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_d_r <= 1'b0;
            sda_d_r <= 1'b0;
            settle_r <= 2'h0;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            settle_r <= {settle_r[0], 1'b1};
        end
    end

    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // the link logic is held in reset outside a frame and for one cycle at
    // every START; both edges fall while SCL is high, far from any SCL edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_frame_r <= 1'b0;
            engine_run_r <= 1'b0;
        end else begin
            in_frame_r <= start_det | (in_frame_r & ~stop_det);
            engine_run_r <= in_frame_r & ~start_det & ~stop_det;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strap decode: watch the strap against the rails and both bus lines

    logic strap_hi_seen_r, strap_lo_seen_r, strap_ne_scl_r, strap_ne_sda_r;
    logic [1:0] strap_bits;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_hi_seen_r <= 1'b0;
            strap_lo_seen_r <= 1'b0;
            strap_ne_scl_r <= 1'b0;
            strap_ne_sda_r <= 1'b0;
        end else if (settle_r[1]) begin
            strap_hi_seen_r <= strap_hi_seen_r | strap_s;
            strap_lo_seen_r <= strap_lo_seen_r | ~strap_s;
            strap_ne_scl_r <= strap_ne_scl_r | (strap_s ^ scl_s);
            strap_ne_sda_r <= strap_ne_sda_r | (strap_s ^ sda_s);
        end
    end

    assign strap_bits = !strap_lo_seen_r ? wir_pkg::STRAP_VCC :
                        !strap_hi_seen_r ? wir_pkg::STRAP_GND :
                        !strap_ne_scl_r ? wir_pkg::STRAP_SCL :
                        !strap_ne_sda_r ? wir_pkg::STRAP_SDA :
                        wir_pkg::STRAP_GND;

    ////////////////////////////////////////////////////////////////////////////
    // link logic (scl domain)

    logic engine_rst;
    logic [1:0] strap_link;
    logic [7:0] own_addr;
    wir_pkg::wir_link_state_t state_r, state_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic [6:0] shift_r;
    logic [7:0] byte_in;
    logic [7:0] ptr_r, ptr_nxt;
    logic ack_req_r, ack_nxt;
    logic last_bit, data_take;
    logic [7:0] wr_addr_link_r, wr_data_link_r;
    logic wr_tgl_link_r, sda_oe_r;

    assign engine_rst = rst | ~engine_run_r;

    wir_sync2 #(.WIDTH(2)) u_strap_sync (
        .clk(scl),
        .rst(rst),
        .d(strap_bits),
        .q(strap_link)
    );

    assign own_addr = {wir_pkg::ADDR_HI, strap_link, wir_pkg::direction_bit};
    assign byte_in = {shift_r, sda_i};
    assign last_bit = (bit_cnt_r == wir_pkg::LAST_DATA_BIT);
    assign data_take = last_bit & (state_r == wir_pkg::LINK_DATA);

    always_comb begin
        state_nxt = state_r;
        ptr_nxt = ptr_r;
        ack_nxt = 1'b0;
        bit_cnt_nxt = (bit_cnt_r == wir_pkg::ACK_BIT) ? 4'h0 : bit_cnt_r + 4'h1;
        if (last_bit) begin
            unique case (state_r)
                wir_pkg::LINK_ADDR: begin
                    if (byte_in == own_addr) begin
                        ack_nxt = 1'b1;
                        state_nxt = wir_pkg::LINK_PTR;
                    end else begin
                        state_nxt = wir_pkg::LINK_IGNORE;
                    end
                end
                wir_pkg::LINK_PTR: begin
                    ptr_nxt = byte_in;
                    ack_nxt = 1'b1;
                    state_nxt = wir_pkg::LINK_DATA;
                end
                wir_pkg::LINK_DATA: begin
                    ptr_nxt = ptr_r + 8'h01;
                    ack_nxt = 1'b1;
                end
                wir_pkg::LINK_IGNORE: begin
                    ack_nxt = 1'b0;
                end
            endcase
        end
    end

    // bits are taken on the rising SCL edge, while SCL is high
    always_ff @(posedge scl or posedge engine_rst) begin
        if (engine_rst) begin
            state_r <= wir_pkg::LINK_ADDR;
            bit_cnt_r <= 4'h0;
            shift_r <= 7'h00;
            ptr_r <= 8'h00;
            ack_req_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= byte_in[6:0];
            ptr_r <= ptr_nxt;
            ack_req_r <= ack_nxt;
        end
    end

    // write payload survives the frame reset so the toggle never jumps
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            wr_addr_link_r <= 8'h00;
            wr_data_link_r <= 8'h00;
            wr_tgl_link_r <= 1'b0;
        end else if (data_take) begin
            wr_addr_link_r <= ptr_r;
            wr_data_link_r <= byte_in;
            wr_tgl_link_r <= ~wr_tgl_link_r;
        end
    end

    // acknowledge changes only while SCL is low
    always_ff @(negedge scl or posedge engine_rst) begin
        if (engine_rst) begin
            sda_oe_r <= 1'b0;
        end else begin
            sda_oe_r <= ack_req_r;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_r;

    ////////////////////////////////////////////////////////////////////////////
    // write crossing into clk domain: toggle synchronised, payload stable

    logic wr_tgl_s, wr_tgl_d_r, wr_fire;
    logic [7:0] wr_addr, wr_data;

    wir_sync2 #(.WIDTH(1)) u_wr_sync (
        .clk(clk),
        .rst(rst),
        .d(wr_tgl_link_r),
        .q(wr_tgl_s)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_tgl_d_r <= 1'b0;
        end else begin
            wr_tgl_d_r <= wr_tgl_s;
        end
    end

    // payload was written on the same SCL edge as the toggle, at least one clk cycle before it arrives
    assign wr_fire = wr_tgl_s ^ wr_tgl_d_r;
    assign wr_addr = wr_addr_link_r;
    assign wr_data = wr_data_link_r;

    ////////////////////////////////////////////////////////////////////////////
    // register decode

    logic hit_shutdown, hit_duty, hit_ctrl, hit_global, hit_freq;
    logic do_update, do_reset;
    logic [5:0] duty_idx, ctrl_idx;

    assign hit_shutdown = wr_fire & (wr_addr == wir_pkg::REG_SHUTDOWN);
    assign hit_duty = wr_fire & wir_pkg::wir_in_range(wr_addr, wir_pkg::REG_DUTY_FIRST,
                                                      wir_pkg::REG_DUTY_LAST);
    assign hit_ctrl = wr_fire & wir_pkg::wir_in_range(wr_addr, wir_pkg::REG_CTRL_FIRST,
                                                      wir_pkg::REG_CTRL_LAST);
    assign hit_global = wr_fire & (wr_addr == wir_pkg::REG_GLOBAL);
    assign hit_freq = wr_fire & (wr_addr == wir_pkg::REG_FREQ);
    assign do_update = wr_fire & (wr_addr == wir_pkg::REG_UPDATE)
                       & (wr_data == wir_pkg::TRIGGER_VALUE);
    assign do_reset = wr_fire & (wr_addr == wir_pkg::REG_SOFT_RESET)
                      & (wr_data == wir_pkg::TRIGGER_VALUE);
    assign duty_idx = wir_pkg::wir_chan_index(wr_addr, wir_pkg::REG_DUTY_FIRST);
    assign ctrl_idx = wir_pkg::wir_chan_index(wr_addr, wir_pkg::REG_CTRL_FIRST);

    ////////////////////////////////////////////////////////////////////////////
    // global registers

    logic [7:0] shutdown_control_r, global_output_control_r, frequency_select_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shutdown_control_r <= wir_pkg::RST_SHUTDOWN;
            global_output_control_r <= wir_pkg::RST_GLOBAL;
            frequency_select_r <= wir_pkg::RST_FREQ;
        end else if (do_reset) begin
            shutdown_control_r <= wir_pkg::RST_SHUTDOWN;
            global_output_control_r <= wir_pkg::RST_GLOBAL;
            frequency_select_r <= wir_pkg::RST_FREQ;
        end else begin
            if (hit_shutdown) begin
                shutdown_control_r <= wr_data;
            end
            if (hit_global) begin
                global_output_control_r <= wr_data;
            end
            if (hit_freq) begin
                frequency_select_r <= wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel shadow and active registers

    logic [wir_pkg::NUM_CH-1:0][7:0] duty_shadow_r;
    logic [wir_pkg::NUM_CH-1:0][7:0] duty_shadow_nxt;
    logic [wir_pkg::NUM_CH-1:0][7:0] duty_active_r;
    logic [wir_pkg::NUM_CH-1:0][2:0] ctrl_shadow_r;
    logic [wir_pkg::NUM_CH-1:0][2:0] ctrl_shadow_nxt;
    logic [wir_pkg::NUM_CH-1:0][2:0] ctrl_active_r;

    always_comb begin
        duty_shadow_nxt = duty_shadow_r;
        ctrl_shadow_nxt = ctrl_shadow_r;
        for (int i = 0; i < wir_pkg::NUM_CH; i++) begin
            if (hit_duty && (duty_idx == 6'(i))) begin
                duty_shadow_nxt[i] = wr_data;
            end
            if (hit_ctrl && (ctrl_idx == 6'(i))) begin
                ctrl_shadow_nxt[i] = wr_data[2:0];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            duty_shadow_r <= {wir_pkg::NUM_CH{wir_pkg::RST_DUTY}};
            ctrl_shadow_r <= {wir_pkg::NUM_CH{wir_pkg::RST_CTRL}};
        end else if (do_reset) begin
            duty_shadow_r <= {wir_pkg::NUM_CH{wir_pkg::RST_DUTY}};
            ctrl_shadow_r <= {wir_pkg::NUM_CH{wir_pkg::RST_CTRL}};
        end else begin
            duty_shadow_r <= duty_shadow_nxt;
            ctrl_shadow_r <= ctrl_shadow_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            duty_active_r <= {wir_pkg::NUM_CH{wir_pkg::RST_DUTY}};
            ctrl_active_r <= {wir_pkg::NUM_CH{wir_pkg::RST_CTRL}};
        end else if (do_reset) begin
            duty_active_r <= {wir_pkg::NUM_CH{wir_pkg::RST_DUTY}};
            ctrl_active_r <= {wir_pkg::NUM_CH{wir_pkg::RST_CTRL}};
        end else if (do_update) begin
            duty_active_r <= duty_shadow_r;
            ctrl_active_r <= ctrl_shadow_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign duty_level = duty_active_r;

    always_comb begin
        for (int i = 0; i < wir_pkg::NUM_CH; i++) begin
            channel_on[i] = ctrl_active_r[i][wir_pkg::CTRL_ON_BIT];
            current_scale_field[i] =
                ctrl_active_r[i][wir_pkg::CTRL_SCALE_MSB:wir_pkg::CTRL_SCALE_LSB];
        end
    end

    assign soft_power_down_bit = shutdown_control_r[wir_pkg::SHUTDOWN_RUN_BIT];
    assign global_output_off = global_output_control_r[wir_pkg::GLOBAL_OFF_BIT];
    assign pwm_rate_select_bit = frequency_select_r[wir_pkg::FREQ_SEL_BIT];

endmodule : wir_reg_port

//--- rtl/wir_pkg.sv
package wir_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int NUM_CH = 36;

    ////////////////////////////////////////////////////////////////////////////
    // target address: fixed upper five bits, two strap bits, direction bit
    localparam logic [4:0] ADDR_HI = 5'h0F;
    localparam logic direction_bit = 1'b0;

    // strap decode results
    localparam logic [1:0] STRAP_GND = 2'h0;
    localparam logic [1:0] STRAP_VCC = 2'h3;
    localparam logic [1:0] STRAP_SCL = 2'h1;
    localparam logic [1:0] STRAP_SDA = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] REG_SHUTDOWN = 8'h00;
    localparam logic [7:0] REG_DUTY_FIRST = 8'h01;
    localparam logic [7:0] REG_DUTY_LAST = 8'h24;
    localparam logic [7:0] REG_UPDATE = 8'h25;
    localparam logic [7:0] REG_CTRL_FIRST = 8'h26;
    localparam logic [7:0] REG_CTRL_LAST = 8'h49;
    localparam logic [7:0] REG_GLOBAL = 8'h4A;
    localparam logic [7:0] REG_FREQ = 8'h4B;
    localparam logic [7:0] REG_SOFT_RESET = 8'h4F;

    // value that fires the update and reset triggers
    localparam logic [7:0] TRIGGER_VALUE = 8'h00;

    // reset values
    localparam logic [7:0] RST_SHUTDOWN = 8'h00;
    localparam logic [7:0] RST_DUTY = 8'h00;
    localparam logic [2:0] RST_CTRL = 3'h0;
    localparam logic [7:0] RST_GLOBAL = 8'h00;
    localparam logic [7:0] RST_FREQ = 8'h00;

    // field positions
    localparam int SHUTDOWN_RUN_BIT = 0;
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_SCALE_LSB = 1;
    localparam int CTRL_SCALE_MSB = 2;
    localparam int GLOBAL_OFF_BIT = 0;
    localparam int FREQ_SEL_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // link bit counter: bits 0..7 carry the byte, bit 8 is the acknowledge
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;

    typedef enum logic [1:0] {
        LINK_ADDR,
        LINK_PTR,
        LINK_DATA,
        LINK_IGNORE
    } wir_link_state_t;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic wir_in_range(input logic [7:0] ptr, input logic [7:0] lo,
                                          input logic [7:0] hi);
        return (ptr >= lo) && (ptr <= hi);
    endfunction : wir_in_range

    function automatic logic [5:0] wir_chan_index(input logic [7:0] ptr,
                                                  input logic [7:0] first);
        logic [7:0] diff;
        diff = ptr - first;
        return diff[5:0];
    endfunction : wir_chan_index

endpackage : wir_pkg

//--- rtl/wir_sync2.sv
module wir_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // level in, synchronised level out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule : wir_sync2

//--- tb/wir_chk.sv
module wir_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // two-wire bus and strap
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic strap_pin,
    // settings
    input wire logic [wir_pkg::NUM_CH-1:0][7:0] duty_level,
    input wire logic [wir_pkg::NUM_CH-1:0] channel_on,
    input wire logic [wir_pkg::NUM_CH-1:0][1:0] current_scale_field,
    input wire logic soft_power_down_bit,
    input wire logic global_output_off,
    input wire logic pwm_rate_select_bit
);
    timeunit 1ns;
    timeprecision 100ps;
    logic scl_q, sda_q, first_r, ok_r;
    logic [3:0] cnt_r, age_r;
    logic [7:0] sh_r;
    wire logic rise = !scl_q && scl;
    wire logic start = scl_q && scl && sda_q && !sda_i;
    wire logic stop = scl_q && scl && !sda_q && sda_i;
    wire logic ninth = rise && cnt_r == 4'h8;
    wire logic [398:0] outs = {duty_level, channel_on, current_scale_field,
        soft_power_down_bit, global_output_off, pwm_rate_select_bit};

    ////////////////////////////////////////////////////////////////////////
    // bit position within the byte, first-byte tracking, age since a byte end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            first_r <= 1'b0;
            ok_r <= 1'b0;
            cnt_r <= 4'h0;
            age_r <= 4'hF;
            sh_r <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda_i;
            sh_r <= rise ? {sh_r[6:0], sda_i} : sh_r;
            cnt_r <= (start || ninth) ? 4'h0 : rise ? cnt_r + 4'h1 : cnt_r;
            first_r <= start ? 1'b1 : ninth ? 1'b0 : first_r;
            ok_r <= (ninth && first_r) ? sda_oe : ok_r;
            age_r <= (rise && cnt_r == 4'h7) ? 4'h0 : (age_r == 4'hF) ? age_r : age_r + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    drive_low_a: assert property (sda_oe |-> !sda_o)
        else $error("sda driven high");
    oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl)
        else $error("sda_oe moved while scl high");
    ack_ninth_a: assert property (rise && sda_oe |-> cnt_r == 4'h8)
        else $error("acknowledge outside ninth clock");
    ack_rise_a: assert property ($rose(sda_oe) |-> cnt_r == 4'h8 ##1 sda_oe [*8])
        else $error("acknowledge started at wrong bit or too short");
    ack_release_a: assert property ($fell(sda_oe) |-> cnt_r == 4'h0)
        else $error("acknowledge released at wrong bit");
    stop_quiet_a: assert property (stop |=> !sda_oe [*8])
        else $error("sda pulled after stop");
    addr_match_a: assert property (
        ninth && first_r && sda_oe |-> sh_r[7:3] == 5'h0F && !sh_r[0])
        else $error("acknowledge of a foreign address");
    mismatch_quiet_a: assert property (ninth && !first_r && !ok_r |-> !sda_oe)
        else $error("acknowledge after refused address");
    out_timing_a: assert property ($changed(outs) |-> age_r < 4'hC)
        else $error("settings changed outside a byte end");
    reset_clear_a: assert property ($fell(rst) |-> outs == '0 && !sda_oe)
        else $error("settings not cleared by reset");
endmodule : wir_chk

//--- tb/wir_master.sv
module wir_master (
    // two-wire bus, master side; sda_m high means released
    output logic scl,
    output logic sda_m,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    task automatic start_bit();
        sda_m = 1'b1;
        scl = 1'b1;
        #300;
        sda_m = 1'b0;
        #700;
        scl = 1'b0;
    endtask : start_bit

    // 2.5 us per bit keeps the bus at 400 kHz
    task automatic clock_bit(input logic b, output logic seen);
        sda_m = b;
        #700;
        scl = 1'b1;
        seen = sda;
        #1200; // data held through the high phase
        scl = 1'b0;
        #600;
    endtask : clock_bit

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], s);
        end
        clock_bit(1'b1, s);
        ack = (s === 1'b0);
    endtask : send_byte

    task automatic stop_bit();
        sda_m = 1'b0;
        #700;
        scl = 1'b1;
        #700;
        sda_m = 1'b1;
        #1300;
    endtask : stop_bit
endmodule : wir_master

//--- tb/tb_wir_reg_port.sv
module tb_wir_reg_port;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LIMIT = 105000;
    logic clk, rst, scl, sda_m, sda_o, sda_oe;
    logic [wir_pkg::NUM_CH-1:0][7:0] duty_level;
    logic [wir_pkg::NUM_CH-1:0] channel_on;
    logic [wir_pkg::NUM_CH-1:0][1:0] current_scale_field;
    logic soft_power_down_bit, global_output_off, pwm_rate_select_bit;
    int strap_sel, error_cnt, comparisons, cyc;
    int sh_d[36], sh_c[36], ac_d[36], ac_c[36], sd_m, gl_m, fq_m;
    logic [1:0] sb[4] = '{2'h0, 2'h3, 2'h1, 2'h2};
    // open-drain wire with pull-up
    wire logic sda = (sda_oe ? sda_o : 1'b1) & sda_m;
    wire logic strap_pin = (strap_sel == 0) ? 1'b0 : (strap_sel == 1) ? 1'b1 :
        (strap_sel == 2) ? scl : sda;

    wir_reg_port wir_reg_port_i (.clk(clk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .strap_pin(strap_pin), .duty_level(duty_level),
        .channel_on(channel_on), .current_scale_field(current_scale_field),
        .soft_power_down_bit(soft_power_down_bit), .global_output_off(global_output_off),
        .pwm_rate_select_bit(pwm_rate_select_bit));
    wir_master wir_master_i (.scl(scl), .sda_m(sda_m), .sda(sda));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic mclear();
        sh_d = '{default: 0};
        sh_c = '{default: 0};
        ac_d = '{default: 0};
        ac_c = '{default: 0};
        sd_m = 0;
        gl_m = 0;
        fq_m = 0;
    endtask : mclear

    task automatic mwrite(input int p, input int d);
        if (p == 8'h00) sd_m = d;
        if (p >= 8'h01 && p <= 8'h24) sh_d[p - 8'h01] = d;
        if (p >= 8'h26 && p <= 8'h49) sh_c[p - 8'h26] = d & 7;
        if (p == 8'h4A) gl_m = d;
        if (p == 8'h4B) fq_m = d;
        if (p == 8'h25 && d == 0) begin
            ac_d = sh_d;
            ac_c = sh_c;
        end
        if (p == 8'h4F && d == 0) mclear();
    endtask : mwrite

    task automatic compare_all();
        repeat (20) @(negedge clk);
        for (int i = 0; i < 36; i++) begin
            check("duty", duty_level[i], 8'(ac_d[i]));
            check("on", {7'h0, channel_on[i]}, 8'(ac_c[i] & 1));
            check("scale", {6'h0, current_scale_field[i]}, 8'(ac_c[i] >> 1));
        end
        check("run", {7'h0, soft_power_down_bit}, 8'(sd_m & 1));
        check("gate", {7'h0, global_output_off}, 8'(gl_m & 1));
        check("rate", {7'h0, pwm_rate_select_bit}, 8'(fq_m & 1));
    endtask : compare_all

    // keep: go on clocking bytes after a refused address
    task automatic frame(input logic [7:0] q[$], input bit hit, input bit keep);
        logic ack;
        wir_master_i.start_bit();
        foreach (q[i]) begin
            wir_master_i.send_byte(q[i], ack);
            check("ack", {7'h0, ack}, {7'h0, hit});
            if (hit && i > 1) mwrite((int'(q[1]) + i - 2) & 255, int'(q[i]));
            if (!ack && !keep) break;
        end
        wir_master_i.stop_bit();
        compare_all();
    endtask : frame

    task automatic do_reset(input int s);
        @(negedge clk);
        rst = 1'b1;
        strap_sel = s;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (10) @(negedge clk);
        mclear();
    endtask : do_reset

    task automatic give_verdict();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] adr;
        logic [7:0] d;
        logic [7:0] q[$];
        rst = 1'b1;
        strap_sel = 0;
        error_cnt = 0;
        comparisons = 0;
        cyc = 0;
        d = 8'($urandom(32'h7AC2A315));
        for (int s = 0; s < 4; s++) begin
            do_reset(s);
            compare_all();
            adr = {5'h0F, sb[s], 1'b0};
            frame({adr}, 1, 0);
            frame({adr ^ 8'h06}, 0, 0);
        end
        frame({adr ^ 8'h80, 8'h00, 8'h01}, 0, 1);
        frame({adr | 8'h01}, 0, 0);
        q = {adr, 8'h23};
        for (int i = 0; i < 5; i++) begin
            d = 8'($urandom());
            q.push_back((i == 2) ? (d | 8'h01) : d);
        end
        frame(q, 1, 0);
        frame({adr, 8'h25, 8'h00}, 1, 0);
        q = {adr, 8'h48};
        for (int i = 0; i < 5; i++) begin
            d = 8'($urandom());
            q.push_back((i == 3) ? 8'h01 : d);
        end
        frame(q, 1, 0);
        frame({adr, 8'h25, 8'h00}, 1, 0);
        frame({adr, 8'h00, 8'h01}, 1, 0);
        frame({adr, 8'h4F, 8'h01}, 1, 0);
        frame({adr, 8'h4F, 8'h00}, 1, 0);
        give_verdict();
    end
endmodule : tb_wir_reg_port

bind wir_reg_port wir_chk wir_chk_i (.clk(clk), .rst(rst), .scl(scl), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .strap_pin(strap_pin), .duty_level(duty_level),
    .channel_on(channel_on), .current_scale_field(current_scale_field),
    .soft_power_down_bit(soft_power_down_bit), .global_output_off(global_output_off),
    .pwm_rate_select_bit(pwm_rate_select_bit));
